// *** rtl/vram_frontend_pkg.sv ***
// constants and types shared by the video RAM access front end
`default_nettype none
package vram_frontend_pkg;
    // address field widths
    localparam int unsigned BANK_W       = 2;
    localparam int unsigned ROW_W        = 11;
    localparam int unsigned COL_W        = 11;
    // wait-state counter width and reset value of programmed wait count
    localparam int unsigned WAIT_CNT_W   = 4;
    localparam logic [3:0]  WAIT_CNT_RST = 4'h0;
    // row strobe precharge time in ns and derived cycle count (rounded up)
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned PRECHARGE_NS  = 60;
    localparam int unsigned PRECHARGE_CYC =
        (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // refresh row strobe low time in ns and derived cycle count (rounded up)
    localparam int unsigned REFRESH_NS    = 100;
    localparam int unsigned REFRESH_CYC   =
        (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // access modes of the primary port strobe
    localparam logic        MODE_LATCH   = 1'b0;
    localparam logic        MODE_STROBE  = 1'b1;
    // array owner states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PORT_A,
        ST_PORT_B,
        ST_REFRESH,
        ST_PRECHARGE
    } array_state_t;
endpackage
`default_nettype wire

// *** rtl/vram_port_access_frontend.sv ***
// access request front end: port strobes, arbitration and row strobe control
// What this block does
// - refresh disable low suppresses internal refreshes; external refresh needs it held low.
// - mode 0: latch enable with chip select sets an access-pending latch.
// - mode 0: pending access starts on the earliest available rising clock edge.
// - mode 1: address strobe with chip select asserts row strobe at once if idle.
// - mode 1: if busy, row strobe asserts on earliest rising edge after event.
// - falling strobe edge captures bank, row and column when latching is enabled.
// - negating the primary request with the strobe released negates row strobe and ends the access.
// - style bit low: wait output drives low while the processor must wait.
// - style bit high: output negated while waiting, asserted once access done.
// - wait or ack transition delayed by a programmed count of rising edges.
// - wait-extend input held during access adds rising edges before the flip.
// - port b request latches address when programmed, only if it starts at once on a free array, and posts a port b access.
// - port b row strobe asserts at once if free, else on earliest edge.
// - port b early ack asserts together with the port b row strobe.
// - external refresh with refresh disable negated clears the refresh row counter.
`default_nettype none
module vram_port_access_frontend
    import vram_frontend_pkg::*;
#(
    parameter int unsigned ROW_CNT_W = ROW_W
)
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // configuration
    input  wire logic                 access_mode_i,
    input  wire logic                 addr_latch_en_i,
    input  wire logic                 wait_style_select_bit_i,
    input  wire logic [WAIT_CNT_W-1:0] wait_count_i,
    // refresh control
    input  wire logic                 refresh_disable_n_i,
    input  wire logic                 ext_refresh_req_n_i,
    input  wire logic                 int_refresh_tick_i,
    // port a
    input  wire logic                 addr_strobe_n_i,
    input  wire logic                 chip_select_n_i,
    input  wire logic                 port_a_access_req_n_i,
    input  wire logic                 wait_extend_in_n_i,
    input  wire logic [BANK_W-1:0]    bank_addr_i,
    input  wire logic [ROW_W-1:0]     row_addr_i,
    input  wire logic [COL_W-1:0]     col_addr_i,
    // port b
    input  wire logic                 port_b_access_req_n_i,
    // outputs
    output logic                      access_ras_n_o,
    output logic                      refresh_ras_n_o,
    output logic                      transfer_ack_n_o,
    output logic                      port_b_early_ack_n_o,
    output logic [BANK_W-1:0]         bank_q_o,
    output logic [ROW_W-1:0]          row_q_o,
    output logic [COL_W-1:0]          col_q_o,
    output logic [ROW_CNT_W-1:0]      refresh_row_o
);
    array_state_t         state_reg;
    array_state_t         state_next;
    logic                 pend_a_reg;
    logic                 pend_ref_reg;
    logic                 strobe_d_reg;
    logic [3:0]           timer_reg;
    logic [BANK_W-1:0]    bank_reg;
    logic [ROW_W-1:0]     row_reg;
    logic [COL_W-1:0]     col_reg;
    logic [ROW_CNT_W-1:0] rrow_reg;

    wire strobe_on   = !addr_strobe_n_i && !chip_select_n_i;
    wire strobe_fall = !addr_strobe_n_i && strobe_d_reg && !chip_select_n_i;
    wire req_a       = !port_a_access_req_n_i;
    wire req_b       = !port_b_access_req_n_i;
    wire idle        = (state_reg == ST_IDLE);
    // refresh counter cleared instead of refreshing when disable negated
    wire ref_clear   = !ext_refresh_req_n_i && refresh_disable_n_i;
    // internal ticks only when enabled; external only when internal disabled
    wire ref_req     = (int_refresh_tick_i && refresh_disable_n_i) ||
                       (!ext_refresh_req_n_i && !refresh_disable_n_i);
    // mode 1 strobe asks for the array directly; mode 0 goes through the latch
    wire want_a      = (access_mode_i == MODE_STROBE) ?
                       (strobe_on || pend_a_reg) : (pend_a_reg && req_a);
    wire serve_ref   = pend_ref_reg || ref_req;
    // combinational fast start: row strobe asserts in the same cycle when free
    wire fast_a      = idle && !serve_ref && (access_mode_i == MODE_STROBE)
                       && strobe_on;
    wire fast_b      = idle && !serve_ref && !want_a && req_b;
    wire addr_take   = addr_latch_en_i && (strobe_fall || (fast_b && !strobe_fall));
    // a pending flag clears when its owner is granted; a mode 1 strobe that is
    // served on its own edge never pends, else the array would be taken twice
    wire a_start      = (state_reg != ST_PORT_A) && (state_next == ST_PORT_A);
    wire ref_start    = (state_reg != ST_REFRESH) && (state_next == ST_REFRESH);
    wire pend_a_set   = strobe_fall && !(a_start && !pend_a_reg);
    wire pend_ref_set = ref_req && !(ref_start && !pend_ref_reg);

    // arbitration: refresh first, then port a, then port b; one owner at a time
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (serve_ref)
                    state_next = ST_REFRESH;
                else if (want_a)
                    state_next = ST_PORT_A;
                else if (req_b)
                    state_next = ST_PORT_B;
            end
            ST_PORT_A:
                if (!req_a && !strobe_on)
                    state_next = ST_PRECHARGE;
            ST_PORT_B:
                if (!req_b)
                    state_next = ST_PRECHARGE;
            ST_REFRESH:
                if (timer_reg == 4'(REFRESH_CYC - 1))
                    state_next = ST_PRECHARGE;
            ST_PRECHARGE:
                if (timer_reg == 4'(PRECHARGE_CYC - 1))
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // state, pending latches and phase timer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg    <= ST_IDLE;
            pend_a_reg   <= 1'b0;
            pend_ref_reg <= 1'b0;
            strobe_d_reg <= 1'b1;
            timer_reg    <= 4'h0;
        end
        else
        begin
            state_reg    <= state_next;
            strobe_d_reg <= addr_strobe_n_i;
            timer_reg    <= (state_next != state_reg) ? 4'h0 : timer_reg + 4'h1;
            // set beats clear: a new request in the granting cycle stays pending
            pend_a_reg   <= pend_a_set || (pend_a_reg && !a_start);
            pend_ref_reg <= pend_ref_set || (pend_ref_reg && !ref_start);
        end
    end

    // address capture on falling strobe or on a port b request that starts at once on a free array
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bank_reg <= '0;
            row_reg  <= '0;
            col_reg  <= '0;
        end
        else if (addr_take)
        begin
            bank_reg <= bank_addr_i;
            row_reg  <= row_addr_i;
            col_reg  <= col_addr_i;
        end
    end

    // refresh row counter: advance per refresh, clear on external request while refresh enabled
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rrow_reg <= '0;
        else if (ref_clear)
            rrow_reg <= '0;
        else if (state_reg == ST_REFRESH && state_next == ST_PRECHARGE)
            rrow_reg <= rrow_reg + 1'b1;
    end

    // strobe outputs; the fast paths are combinational so the start is immediate
    assign access_ras_n_o       = !((state_reg == ST_PORT_A) || (state_reg == ST_PORT_B)
                                    || fast_a || fast_b);
    assign refresh_ras_n_o      = !(state_reg == ST_REFRESH);
    assign port_b_early_ack_n_o = !((state_reg == ST_PORT_B) || fast_b);
    assign bank_q_o             = bank_reg;
    assign row_q_o              = row_reg;
    assign col_q_o              = col_reg;
    assign refresh_row_o        = rrow_reg;

    // wait or acknowledge for port a accesses only
    wait_state_gen #(
        .CNT_W (WAIT_CNT_W)
    ) u_wait (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .access_active_i         (state_reg == ST_PORT_A),
        .wait_count_i            (wait_count_i),
        .wait_style_select_bit_i (wait_style_select_bit_i),
        .wait_extend_in_n_i      (wait_extend_in_n_i),
        .transfer_ack_n_o        (transfer_ack_n_o)
    );

    property p_one_owner;
        @(posedge clk_i) disable iff (rst_i)
        !(!refresh_ras_n_o && !access_ras_n_o);
    endproperty
    a_one_owner: assert property (p_one_owner)
        else $error("refresh and access strobes asserted together");

    property p_req_drop_ends;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == ST_PORT_A && !req_a && !strobe_on |=> access_ras_n_o [*2];
    endproperty
    a_req_drop_ends: assert property (p_req_drop_ends)
        else $error("row strobe held after request negated");

    property p_early_ack;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == ST_PORT_B |-> !port_b_early_ack_n_o && !access_ras_n_o;
    endproperty
    a_early_ack: assert property (p_early_ack)
        else $error("port b early ack not with row strobe");

    property p_mode1_fast;
        @(posedge clk_i) disable iff (rst_i)
        access_mode_i && idle && strobe_on && !serve_ref |-> !access_ras_n_o;
    endproperty
    a_mode1_fast: assert property (p_mode1_fast)
        else $error("mode 1 strobe did not start access at once");

    property p_mode0_start;
        @(posedge clk_i) disable iff (rst_i)
        !access_mode_i && idle && pend_a_reg && req_a && !serve_ref
            |=> state_reg == ST_PORT_A;
    endproperty
    a_mode0_start: assert property (p_mode0_start)
        else $error("mode 0 pending access not started");

    property p_ref_clear;
        @(posedge clk_i) disable iff (rst_i)
        ref_clear |=> rrow_reg == '0;
    endproperty
    a_ref_clear: assert property (p_ref_clear)
        else $error("refresh row counter not cleared");

    property p_no_refresh_disabled;
        @(posedge clk_i) disable iff (rst_i)
        !refresh_disable_n_i && ext_refresh_req_n_i && !pend_ref_reg && idle
            |=> state_reg != ST_REFRESH;
    endproperty
    a_no_refresh_disabled: assert property (p_no_refresh_disabled)
        else $error("internal refresh while disabled");

    property p_cs_ignored;
        @(posedge clk_i) disable iff (rst_i)
        chip_select_n_i && !pend_a_reg && !req_b && idle && !serve_ref
            |=> state_reg != ST_PORT_A;
    endproperty
    a_cs_ignored: assert property (p_cs_ignored)
        else $error("access started without chip select");
endmodule // vram_port_access_frontend
`default_nettype wire

// *** rtl/wait_state_gen.sv ***
// wait or acknowledge output generator with programmed delay and extension
`default_nettype none
module wait_state_gen
    import vram_frontend_pkg::*;
#(
    parameter int unsigned CNT_W = WAIT_CNT_W
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             access_active_i,
    input  wire logic [CNT_W-1:0] wait_count_i,
    input  wire logic             wait_style_select_bit_i,
    input  wire logic             wait_extend_in_n_i,
    // output
    output logic                  transfer_ack_n_o
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             done_reg;
    logic             done_next;
    wire              hold_off;
    wire              reached;

    // extension input freezes the counter, adding clock edges before the flip
    assign hold_off   = ~wait_extend_in_n_i;
    assign reached    = (count_reg >= wait_count_i) && !hold_off;
    assign count_next = !access_active_i ? '0 :
                        ((reached || hold_off) ? count_reg : count_reg + 1'b1);
    assign done_next  = access_active_i && (done_reg || reached);

    // counter of rising edges since access_active_i asserted, one edge after a fast mode 1 row strobe
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end

    // wait style is low while waiting; ack style is low once access is done
    assign transfer_ack_n_o = wait_style_select_bit_i ?
                              ~done_reg :
                              ~(access_active_i && !done_reg);

    // ack style with a count of 2: ack stays negated for three edges from the access start
    property p_ack_not_early;
        @(posedge clk_i) disable iff (rst_i)
        $rose(access_active_i) && wait_style_select_bit_i && wait_count_i == 4'h2
            |-> transfer_ack_n_o [*3];
    endproperty
    a_ack_not_early: assert property (p_ack_not_early)
        else $error("ack asserted before programmed wait count");

    property p_extend_holds;
        @(posedge clk_i) disable iff (rst_i)
        access_active_i && !done_reg && !wait_extend_in_n_i |=> !done_reg;
    endproperty
    a_extend_holds: assert property (p_extend_holds)
        else $error("wait released while extension held");

    property p_wait_style_low;
        @(posedge clk_i) disable iff (rst_i)
        !wait_style_select_bit_i && access_active_i && !done_reg |-> !transfer_ack_n_o;
    endproperty
    a_wait_style_low: assert property (p_wait_style_low)
        else $error("wait output not low while waiting");

    property p_ack_after_done;
        @(posedge clk_i) disable iff (rst_i)
        wait_style_select_bit_i && done_reg |-> !transfer_ack_n_o;
    endproperty
    a_ack_after_done: assert property (p_ack_after_done)
        else $error("ack not asserted after access done");
endmodule // wait_state_gen
`default_nettype wire

// *** testbench/cpu_port_model.sv ***
// bus master model that drives the primary port of the video RAM front end
`default_nettype none
module cpu_port_model
    import vram_frontend_pkg::*;
(
    // clock
    input  wire logic         clk_i,
    // primary port pins
    output logic              addr_strobe_n_o,
    output logic              chip_select_n_o,
    output logic              port_a_access_req_n_o,
    output logic [BANK_W-1:0] bank_addr_o,
    output logic [ROW_W-1:0]  row_addr_o,
    output logic [COL_W-1:0]  col_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels at time zero
    initial
    begin
        addr_strobe_n_o = 1'b1;
        chip_select_n_o = 1'b1;
        port_a_access_req_n_o = 1'b1;
        bank_addr_o = 2'h0;
        row_addr_o = 11'h000;
        col_addr_o = 11'h000;
    end

    // address is set one cycle ahead so it is settled when the strobe falls
    task automatic set_addr(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
                            input logic [COL_W-1:0] c);
        @(posedge clk_i);
        #2;
        bank_addr_o = b;
        row_addr_o = r;
        col_addr_o = c;
    endtask

    // strobe with chip select; request order depends on the access mode
    task automatic start_access(input logic mode, input logic cs_n);
        @(posedge clk_i);
        #2;
        chip_select_n_o = cs_n;
        addr_strobe_n_o = 1'b0;
        if (mode == MODE_STROBE)
            port_a_access_req_n_o = 1'b0; // request before strobe release
        else
        begin
            @(posedge clk_i);
            #2;
            port_a_access_req_n_o = 1'b0; // request after the first edge
            addr_strobe_n_o = 1'b1;
        end
    endtask

    // release everything; a floating bus must not keep showing the old address
    task automatic end_access;
        @(posedge clk_i);
        #2;
        port_a_access_req_n_o = 1'b1;
        addr_strobe_n_o = 1'b1;
        chip_select_n_o = 1'b1;
        bank_addr_o = ~bank_addr_o;
        row_addr_o = ~row_addr_o;
        col_addr_o = ~col_addr_o;
    endtask
endmodule // cpu_port_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the video RAM access front end
`default_nettype none
module tb_top
    import vram_frontend_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, mode, latch_en, style, rdis_n, ext_rf_n, tick, ext_n, pb_n;
    logic strobe_n, cs_n, req_n, ras_n, rras_n, ack_n, pb_ack_n;
    logic [3:0] wcnt;
    logic [BANK_W-1:0] bank, bank_q, exp_bank;
    logic [ROW_W-1:0] row, row_q, rrow, exp_row;
    logic [COL_W-1:0] col, col_q, exp_col;
    int errors, checked, seed, n, k, w;

    vram_port_access_frontend i_vram_port_access_frontend (
        .clk_i(clk), .rst_i(rst), .access_mode_i(mode), .addr_latch_en_i(latch_en),
        .wait_style_select_bit_i(style), .wait_count_i(wcnt),
        .refresh_disable_n_i(rdis_n), .ext_refresh_req_n_i(ext_rf_n),
        .int_refresh_tick_i(tick), .addr_strobe_n_i(strobe_n), .chip_select_n_i(cs_n),
        .port_a_access_req_n_i(req_n), .wait_extend_in_n_i(ext_n), .bank_addr_i(bank),
        .row_addr_i(row), .col_addr_i(col), .port_b_access_req_n_i(pb_n),
        .access_ras_n_o(ras_n), .refresh_ras_n_o(rras_n), .transfer_ack_n_o(ack_n),
        .port_b_early_ack_n_o(pb_ack_n), .bank_q_o(bank_q), .row_q_o(row_q),
        .col_q_o(col_q), .refresh_row_o(rrow));

    cpu_port_model i_cpu_port_model (
        .clk_i(clk), .addr_strobe_n_o(strobe_n), .chip_select_n_o(cs_n),
        .port_a_access_req_n_o(req_n), .bank_addr_o(bank), .row_addr_o(row),
        .col_addr_o(col));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // 0 access strobe, 1 refresh strobe, 2 port b ack, 3 wait output flipped to done
    function automatic logic sig(input int sel);
        case (sel)
            0: return ras_n;
            1: return rras_n;
            2: return pb_ack_n;
            default: return ack_n ^ ~style;
        endcase
    endfunction

    // bounded wait for a low level; the extend input is released after k edges
    task automatic wait_low(input int sel, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #2;
            cnt++;
            if (cnt >= k)
                ext_n = 1'b1;
        end
        while (sig(sel) !== 1'b0 && cnt < 40);
    endtask

    task automatic precharge;
        repeat (PRECHARGE_CYC + 2) @(posedge clk);
        #2;
    endtask

    // hang guard, well beyond the expected run of a few hundred cycles
    initial
    begin
        #200000;
        errors++;
        give_verdict();
    end

    initial
    begin
        seed = 32'h122284C9;
        {clk, rst, mode, latch_en, style, tick, k} = {1'b0, 1'b1, MODE_STROBE, 3'b110, 32'h0};
        {rdis_n, ext_rf_n, ext_n, pb_n, wcnt} = {4'hF, WAIT_CNT_RST};
        {errors, checked, exp_bank, exp_row, exp_col} = '0;
        repeat (16) @(posedge clk);
        #2 rst = 1'b0;
        // random primary port accesses in both modes and both wait styles
        for (int i = 0; i < 12; i++)
        begin
            {mode, style, latch_en} = (i < 2) ? {i[0], 2'b11} : $random(seed);
            w = $random(seed) & 32'h7;
            k = $random(seed) & 32'h3;
            wcnt = w[3:0];
            i_cpu_port_model.set_addr($random(seed), $random(seed), $random(seed));
            if (latch_en)
                {exp_bank, exp_row, exp_col} = {bank, row, col};
            i_cpu_port_model.start_access(mode, 1'b0);
            #1 check(ras_n, (mode == MODE_STROBE) ? 1'b0 : 1'b1);
            @(posedge clk);
            #2;
            ext_n = (k > 0) ? 1'b0 : 1'b1;
            check(ras_n, 1'b0);
            check(ack_n, style);
            wait_low(3, n);
            check(n, w + 1 + k);
            check({bank_q, row_q, col_q}, {exp_bank, exp_row, exp_col});
            i_cpu_port_model.end_access();
            @(posedge clk);
            #2;
            check(ras_n, 1'b1);
            k = 0;
            precharge();
        end
        // strobe without chip select is ignored
        i_cpu_port_model.start_access(MODE_STROBE, 1'b1);
        repeat (3) @(posedge clk);
        #2 check(ras_n, 1'b1);
        i_cpu_port_model.end_access();
        precharge();
        // port b right behind a primary access has to wait out the precharge
        {mode, latch_en} = {MODE_STROBE, 1'b1};
        i_cpu_port_model.start_access(MODE_STROBE, 1'b0);
        repeat (3) @(posedge clk);
        i_cpu_port_model.end_access();
        pb_n = 1'b0;
        #1 check(pb_ack_n, 1'b1);
        wait_low(2, n);
        check(n <= PRECHARGE_CYC + 3, 1'b1);
        check(ras_n, 1'b0);
        @(posedge clk);
        #2 pb_n = 1'b1;
        precharge();
        // port b on a free array starts at once and latches the address
        i_cpu_port_model.set_addr(2'h2, 11'h5A5, 11'h3C3);
        @(posedge clk);
        #2 pb_n = 1'b0;
        #1 check({ras_n, pb_ack_n}, 2'b00);
        @(posedge clk);
        #2 check({bank_q, row_q, col_q}, {2'h2, 11'h5A5, 11'h3C3});
        pb_n = 1'b1;
        precharge();
        // internal refresh, with a primary request arriving while it runs
        tick = 1'b1;
        @(posedge clk);
        #2 tick = 1'b0;
        wait_low(1, n);
        check(n <= 4, 1'b1);
        i_cpu_port_model.start_access(MODE_STROBE, 1'b0);
        check(ras_n, 1'b1);
        wait_low(0, n);
        check(n <= REFRESH_CYC + PRECHARGE_CYC + 4, 1'b1);
        check(rras_n, 1'b1);
        i_cpu_port_model.end_access();
        precharge();
        // refresh disabled: the timer tick is ignored, an external request is served
        rdis_n = 1'b0;
        tick = 1'b1;
        @(posedge clk);
        #2 tick = 1'b0;
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            #2 n = n | (rras_n !== 1'b1);
        end
        check(n, 0);
        ext_rf_n = 1'b0;
        @(posedge clk);
        #2 ext_rf_n = 1'b1;
        wait_low(1, n);
        check(n <= 4, 1'b1);
        repeat (REFRESH_CYC + PRECHARGE_CYC + 4) @(posedge clk);
        // external request with refresh enabled clears the row counter
        #2 rdis_n = 1'b1;
        check(rrow, 11'h002);
        ext_rf_n = 1'b0;
        @(posedge clk);
        #2 ext_rf_n = 1'b1;
        repeat (2) @(posedge clk);
        #2 check(rrow, 11'h000);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
